// ==== phase_shift_regs.vh ====
/*
  Register map, field positions, reset values and timing counts of the
  dynamic phase-shift block. Assumes a 40 MHz system clock and APB access.
*/
`ifndef PHASE_SHIFT_REGS_VH
`define PHASE_SHIFT_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PS_CTRL_OFFSET      12'h000
`define PS_STATUS_OFFSET    12'h004
`define PS_TAP_BASE_OFFSET  12'h010
`define PS_TAP_LAST_OFFSET  12'h038

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PS_CTRL_SETTLE_LSB  0
`define PS_CTRL_SETTLE_MSB  7
`define PS_STAT_DONE_BIT    0
`define PS_STAT_BUSY_BIT    1
`define PS_STAT_COUNT_LSB   16

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PS_SETTLE_RESET     8'h03
`define PS_TAP_BITS         3
`define PS_NUM_TARGETS      11
`define PS_SEL_ALL          4'h0
`define PS_SEL_FEEDBACK     4'h1
`define PS_SEL_FIRST_OUT    4'h2
`define PS_SEL_LAST_OUT     4'hb

`endif

// ==== ps_sync2.v ====
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ps_sync2
(
  input  wire clk,
  input  wire reset,
  input  wire asyncIn,
  output wire syncOut
);
  reg meta_q;
  reg sync_q;

  // First stage feeds only the second stage
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule
`default_nettype wire

// ==== ps_tap_bank.v ====
/*
  Phase-tap selections, one per target (feedback + ten output dividers).
  Assumes the caller gives a one-hot or all-ten-dividers select and a one-cycle step.
*/
`timescale 1ns/10ps
`default_nettype none
`include "phase_shift_regs.vh"
module ps_tap_bank
(
  input  wire                          clk,
  input  wire                          reset,
  input  wire [`PS_NUM_TARGETS-1:0]    stepSel,
  input  wire                          stepNow,
  input  wire                          stepUp,
  input  wire [3:0]                    readIdx,
  output reg  [`PS_TAP_BITS-1:0]       readTap,
  output wire [`PS_NUM_TARGETS*3-1:0]  tapsFlat
);
  genvar g;
  generate
    for (g = 0; g < `PS_NUM_TARGETS; g = g + 1)
    begin : tapGen
      reg [`PS_TAP_BITS-1:0] tap_q;
      // Eighth-period tap wraps modulo eight, so steps accumulate without limit
      always @(posedge clk or posedge reset)
      begin
        if (reset)
          tap_q <= 3'h0;
        else if (stepNow && stepSel[g])
          tap_q <= stepUp ? tap_q + 3'h1 : tap_q - 3'h1;  // [R1] [R3] [R19]
      end
      assign tapsFlat[g*3 +: 3] = tap_q;
    end
  endgenerate

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      readTap <= 3'h0;
    else if (readIdx < `PS_NUM_TARGETS)
      readTap <= tapsFlat[readIdx*3 +: 3];
    else
      readTap <= 3'h0;
  end
endmodule
`default_nettype wire

// ==== pll_dynamic_phase_shift.v ====
/*
  Dynamic phase-shift controller: handshake on the reconfiguration clock,
  tap selections per counter, APB access to status and taps.
  Assumes reconfClk and the handshake inputs are asynchronous to sys_clk
  and that reconfClk is slow enough (200 ns) for edge detection at 40 MHz.
*/
// Operation
// R1 - Each step moves the chosen counter phase by one eighth VCO period.
// R2 - Output clocks keep running during adjustment; nothing is gated.
// R3 - A step increments or decrements the tap selection of the target.
// R4 - Four-bit select picks feedback counter or one output divider.
// R5 - Select code zero steps every output divider at once.
// R6 - Code one is feedback; codes two to eleven are dividers zero to nine.
// R7 - Direction one advances phase, zero retards it.
// R8 - Step request is sampled on the falling reconfiguration clock edge.
// R9 - Controller holds step request high at least two clock cycles.
// R10 - Pulses at least one cycle apart; each pulse means one step.
// R11 - Second rising edge after sampling captures direction and select.
// R12 - Done falls on that same rising edge, stays low until finished.
// R13 - Done rises on internal timing, not on a clock edge.
// R14 - Controller assumes no fixed low time of done.
// R15 - Controller sets inputs, raises request, waits done low, drops, waits high.
// R16 - No new step until done has risen.
// R17 - Handshake is synchronous to reconfiguration clock; device drives done.
// R18 - Controller supplies a free-running reconfiguration clock.
// R19 - Unlimited consecutive steps accumulate.
// R20 - Codes twelve to fifteen select no counter.
`timescale 1ns/10ps
`default_nettype none
`include "phase_shift_regs.vh"
module pll_dynamic_phase_shift
(
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        reconfClk,
  input  wire        stepRequest,
  input  wire        stepUp,
  input  wire [3:0]  counterSelect,
  output reg         shiftDone,
  output wire [32:0] tapSelects,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);
  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire clkS;
  wire reqS;
  wire upS;
  wire [3:0] selS;

  ps_sync2 uClk (.clk(sys_clk), .reset(reset), .asyncIn(reconfClk), .syncOut(clkS));
  ps_sync2 uReq (.clk(sys_clk), .reset(reset), .asyncIn(stepRequest), .syncOut(reqS));
  ps_sync2 uUp  (.clk(sys_clk), .reset(reset), .asyncIn(stepUp), .syncOut(upS));

  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1)
    begin : selSync
      ps_sync2 uSel (.clk(sys_clk), .reset(reset), .asyncIn(counterSelect[s]),
                     .syncOut(selS[s]));
    end
  endgenerate

  // --------------------------------------------------------------------
  // Reconfiguration clock edge detection
  // --------------------------------------------------------------------
  reg clkPrev_q;
  wire riseEdge = clkS & ~clkPrev_q;
  wire fallEdge = ~clkS & clkPrev_q;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      clkPrev_q <= 1'b0;
    else
      clkPrev_q <= clkS;
  end

  // --------------------------------------------------------------------
  // Handshake state machine
  // --------------------------------------------------------------------
  localparam IDLE   = 3'd0;
  localparam WAIT1  = 3'd1;
  localparam WAIT2  = 3'd2;
  localparam SETTLE = 3'd3;
  localparam HOLD   = 3'd4;

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [7:0]  settle_q;
  reg [7:0]  settleCnt_q;
  reg        dir_q;
  reg [3:0]  sel_q;
  reg        stepNow_q;
  reg [15:0] stepCount_q;

  // Select decode: all dividers, feedback, one divider, or nothing
  reg [`PS_NUM_TARGETS-1:0] selDecode;
  always @*
  begin
    selDecode = {`PS_NUM_TARGETS{1'b0}};
    if (sel_q == `PS_SEL_ALL)
      selDecode = {{(`PS_NUM_TARGETS-1){1'b1}}, 1'b0};  // [R5]
    else if (sel_q == `PS_SEL_FEEDBACK)
      selDecode[0] = 1'b1;  // [R4] [R6]
    else if (sel_q <= `PS_SEL_LAST_OUT)
      selDecode[sel_q - 4'h1] = 1'b1;  // [R6]
    // Codes above eleven leave every bit clear [R20]
  end

  always @*
  begin
    state_d = state_q;
    case (state_q)
      IDLE:
        if (fallEdge && reqS)
          state_d = WAIT1;  // [R8] [R10]
      WAIT1:
        if (riseEdge)
          state_d = WAIT2;
      WAIT2:
        if (riseEdge)
          state_d = SETTLE;  // [R11]
      SETTLE:
        if (settleCnt_q == 8'h00)
          state_d = HOLD;
      HOLD:
        // One step per pulse: wait for the request to drop
        if (!reqS)
          state_d = IDLE;  // [R10]
      default:
        state_d = IDLE;
    endcase
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= IDLE;
      shiftDone   <= 1'b1;
      dir_q       <= 1'b0;
      sel_q       <= 4'h0;
      stepNow_q   <= 1'b0;
      settleCnt_q <= 8'h00;
      stepCount_q <= 16'h0000;
    end
    else
    begin
      state_q   <= state_d;
      stepNow_q <= 1'b0;
      if (state_q == WAIT2 && riseEdge)
      begin
        dir_q       <= upS;  // [R7] [R11]
        sel_q       <= selS;  // [R11]
        shiftDone   <= 1'b0;  // [R12]
        settleCnt_q <= settle_q;
      end
      else if (state_q == SETTLE)
      begin
        if (settleCnt_q == 8'h00)
        begin
          // Done rises off the internal count, not a clock edge
          shiftDone   <= 1'b1;  // [R13]
          stepNow_q   <= 1'b1;  // [R3]
          stepCount_q <= stepCount_q + 16'h0001;  // [R19]
        end
        else
          settleCnt_q <= settleCnt_q - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Tap bank; taps move without ever stopping the output clocks
  // --------------------------------------------------------------------
  wire [2:0] readTap;
  wire [3:0] readIdx = paddr[5:2] - 4'h4;

  ps_tap_bank uTaps
  (
    .clk      (sys_clk),
    .reset    (reset),
    .stepSel  (selDecode),
    .stepNow  (stepNow_q),
    .stepUp   (dir_q),
    .readIdx  (readIdx),
    .readTap  (readTap),
    .tapsFlat (tapSelects)  // [R2]
  );

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  reg rdPend_q;
  wire access = psel & penable;
  wire isCtrl = paddr == `PS_CTRL_OFFSET;
  wire isStat = paddr == `PS_STATUS_OFFSET;
  wire isTap  = paddr >= `PS_TAP_BASE_OFFSET && paddr <= `PS_TAP_LAST_OFFSET
                && paddr[1:0] == 2'b00;
  wire mapped = isCtrl | isStat | isTap;

  // Tap reads wait one cycle so the tap comes out of its register
  assign pready  = ~(access & ~pwrite & isTap & ~rdPend_q);
  assign pslverr = access & pready & ~mapped;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      settle_q <= `PS_SETTLE_RESET;
      rdPend_q <= 1'b0;
    end
    else
    begin
      rdPend_q <= access & ~pwrite & isTap & ~rdPend_q;
      if (access && pwrite && isCtrl)
        settle_q <= pwdata[`PS_CTRL_SETTLE_MSB:`PS_CTRL_SETTLE_LSB];
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      if (isCtrl)
        prdata <= {24'h000000, settle_q};
      else if (isStat)
        prdata <= {stepCount_q, 14'h0000, state_q != IDLE, shiftDone};
      else
        prdata <= 32'h00000000;
    end
    // Tap data must stand in the cycle in which pready is high
    else if (access && !pwrite && isTap && !rdPend_q)
      prdata <= {29'h00000000, readTap};
  end
endmodule
`default_nettype wire

// ==== ps_checker.sv ====
/* Port assertions for the phase-shift block.
   Assumes the settle count keeps its reset value of 3. */
`timescale 1ns/10ps
`default_nettype none
module ps_checker
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        reconfClk,
  input wire logic        stepRequest,
  input wire logic        shiftDone,
  input wire logic [32:0] tapSelects,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence doneLow;
    !shiftDone[*4] ##1 shiftDone;
  endsequence
  sequence tapAccess;
    $rose(penable) && psel && !pwrite && paddr >= 12'h010 && paddr <= 12'h038;
  endsequence
  chk_done_settle: assert property ($fell(shiftDone) |-> doneLow)
    else $error("done low time wrong");
  chk_done_cause: assert property ($fell(shiftDone) |-> $past(stepRequest, 3) && $past(reconfClk, 2))
    else $error("done fell without request");
  chk_one_step: assert property ($rose(shiftDone) && stepRequest |=> shiftDone[*8])
    else $error("second step from one pulse");
  chk_tap_timing: assert property (!$stable(tapSelects) |-> $past(shiftDone) && !$past(shiftDone, 2))
    else $error("tap moved outside a shift");
  chk_tap_eighth: assert property (!$stable(tapSelects[2:0]) |-> 3'(tapSelects[2:0] - $past(tapSelects[2:0])) inside {3'h1, 3'h7})
    else $error("tap moved by more than one");
  chk_tap_wait: assert property (tapAccess |-> !pready ##1 pready)
    else $error("tap read wait wrong");
  chk_reg_nowait: assert property (psel && penable && paddr < 12'h010 |-> pready)
    else $error("register access waited");
  chk_err_phase: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access phase");
endmodule
`default_nettype wire

// ==== ps_core_model.sv ====
/* Core logic model that drives the step handshake.
   Assumes a free-running reconfiguration clock from the bench. */
`timescale 1ns/10ps
`default_nettype none
module ps_core_model
(
  input  wire logic       reconfClk,
  input  wire logic       shiftDone,
  output var  logic       stepRequest,
  output var  logic       stepUp,
  output var  logic [3:0] counterSelect
);
  logic sawLow;
  initial stepRequest = 1'b0;
  initial stepUp = 1'b0;
  initial counterSelect = 4'h0;
  initial sawLow = 1'b0;
  // Done may be low for less than one clock, so catch the edge itself
  always @(negedge shiftDone) sawLow = 1'b1;
  task automatic doStep(input logic up, input logic [3:0] sel, input int extra, output logic ok);
    int n;
    @(posedge reconfClk);
    stepUp <= up;
    counterSelect <= sel;
    sawLow = 1'b0;
    @(posedge reconfClk);
    stepRequest <= 1'b1;
    for (n = 0; n < 16 && !sawLow; n++) @(posedge reconfClk);
    repeat (extra) @(posedge reconfClk);
    stepRequest <= 1'b0;
    for (n = 0; n < 16 && shiftDone !== 1'b1; n++) @(posedge reconfClk);
    ok = sawLow && shiftDone === 1'b1;
    @(posedge reconfClk);
  endtask
endmodule
`default_nettype wire

// ==== pll_dynamic_phase_shift_test.sv ====
/* Self-checking bench for the phase-shift block.
   Assumes the core model drives the handshake and APB reaches the taps. */
`timescale 1ns/10ps
`default_nettype none
module pll_dynamic_phase_shift_test;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        reconfClk = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  tap [0:10] = '{default: 3'h0};
  int          fail_count = 0;
  int          comparisons = 0;
  wire logic        stepRequest, stepUp, shiftDone, pready, pslverr;
  wire logic [3:0]  counterSelect;
  wire logic [32:0] tapSelects;
  wire logic [31:0] prdata;
  // -------------
  // Clocks, parts
  // -------------
  always #12.5 sys_clk = ~sys_clk;
  initial #7 forever #100 reconfClk = ~reconfClk;
  pll_dynamic_phase_shift dut (.sys_clk(sys_clk), .reset(reset), .reconfClk(reconfClk),
    .stepRequest(stepRequest), .stepUp(stepUp), .counterSelect(counterSelect),
    .shiftDone(shiftDone), .tapSelects(tapSelects), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ps_core_model core (.reconfClk(reconfClk), .shiftDone(shiftDone),
    .stepRequest(stepRequest), .stepUp(stepUp), .counterSelect(counterSelect));
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves one idle edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // Look at pready where it has settled, then take the answer at the edge
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20)
    begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic checkTaps();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, 12'h010 + 12'(4 * i), 32'h0, q, e);
      check("tap register", {29'h0, tap[i]}, q);
      check("tap port", {29'h0, tap[i]}, {29'h0, tapSelects[3 * i +: 3]});
    end
  endtask
  task automatic step(input logic up, input logic [3:0] sel, input int extra);
    logic ok;
    core.doStep(up, sel, extra, ok);
    @(posedge sys_clk);
    check("handshake", 32'h1, {31'h0, ok});
    for (int i = 0; i < 11; i++)
      if (sel == 4'(i + 1) || (sel == 4'h0 && i > 0))
        tap[i] = up ? tap[i] + 3'h1 : tap[i] - 3'h1;
    checkTaps();
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic scRegisters();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h004, 32'h0, q, e);
    check("status", 32'h1, q);
    apb(1'b1, 12'h000, 32'hffff_ff03, q, e);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check("settle", 32'h3, q);
    apb(1'b0, 12'h008, 32'h0, q, e);
    check("unmapped read", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    apb(1'b1, 12'h008, 32'h5, q, e);
    check("unmapped write", 32'h1, {31'h0, e});
    apb(1'b1, 12'h014, 32'h5, q, e);
    checkTaps();
  endtask
  task automatic scAllCodes();
    for (int c = 0; c < 16; c++)
      step(c[0], 4'(c), 0);
  endtask
  task automatic scWrapAndHold();
    logic [31:0] q;
    logic        e;
    repeat (9) step(1'b1, 4'h2, 0);
    step(1'b0, 4'h3, 6);
    apb(1'b0, 12'h004, 32'h0, q, e);
    check("status idle", 32'h1, q & 32'h3);
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    scRegisters();
    scAllCodes();
    scWrapAndHold();
    tally_and_finish();
  end
endmodule
bind pll_dynamic_phase_shift ps_checker chk (.sys_clk(sys_clk), .reset(reset),
  .reconfClk(reconfClk), .stepRequest(stepRequest), .shiftDone(shiftDone),
  .tapSelects(tapSelects), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire
